// [include/serial_port_pkg.sv]
// Purpose: shared constants for the four-mode serial port
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   all control fields sit in the low byte of their word
package serial_port_pkg;
    // register byte addresses
    localparam logic [3:0] OFS_SERIAL_BUFFER = 4'h0;
    localparam logic [3:0] OFS_SERIAL_CTRL   = 4'h4;
    localparam logic [3:0] OFS_POWER_CTRL    = 4'h8;
    // serial_control_reg field positions
    localparam int CTRL_TX_DONE   = 0;
    localparam int CTRL_RX_DONE   = 1;
    localparam int CTRL_RX_NINTH  = 2;
    localparam int CTRL_TX_NINTH  = 3;
    localparam int CTRL_RX_ENABLE = 4;
    localparam int CTRL_MULTIPROC = 5;
    localparam int CTRL_MODE_LOW  = 6;
    localparam int CTRL_MODE_HIGH = 7;
    // power_control_reg field position
    localparam int PCTRL_BAUD_DBL = 7;
    // operating modes, high select bit first
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_UART8 = 2'b01,
        MODE_FIXED = 2'b10,
        MODE_TIMED = 2'b11
    } mode_e;
    // shift-register mode timing in oscillator clocks
    localparam logic [3:0] M0_PERIOD_FAST = 4'h4;
    localparam logic [3:0] M0_PERIOD_SLOW = 4'hc;
    localparam logic [3:0] M0_LEAD_FAST   = 4'h1;
    localparam logic [3:0] M0_LEAD_SLOW   = 4'h3;
    localparam logic [3:0] M0_LOW_FAST    = 4'h2;
    localparam logic [3:0] M0_LOW_SLOW    = 4'h6;
    localparam logic [2:0] M0_LAST_BIT    = 3'h7;
    // asynchronous framing
    localparam logic [3:0] DIV_LAST      = 4'hf;
    localparam logic [3:0] SMP_FIRST     = 4'h7;
    localparam logic [3:0] SMP_SECOND    = 4'h8;
    localparam logic [3:0] SMP_THIRD     = 4'h9;
    localparam logic [3:0] FRAME_LEN_10  = 4'ha;
    localparam logic [3:0] FRAME_LEN_11  = 4'hb;
    // oversampling prescale in mode 2, minus one
    localparam logic [1:0] PRE_DOUBLE    = 2'h1;
    localparam logic [1:0] PRE_SINGLE    = 2'h3;
endpackage

// [hdl/four_mode_serial_port.sv]
// Purpose: four-mode serial port with a classic Wishbone register slave
// Assumes: clk_i is the oscillator; timer_overflow_i is a one-cycle pulse on clk_i
// Notes:   rxd is a two-way pin, driven only while shifting out in mode 0
// Contract
// - buffer write loads transmitter, read returns receiver
// - mode 0 shifts 8 bits LSB first, drives clock
// - mode 0 rate osc/12, or osc/4 with multiproc
// - fast mode 0: data 1 clk early, low 2
// - slow mode 0: data 3 clks early, low 6
// - mode 0 transmit done after last bit
// - mode 0 receive starts when enabled, flag clear
// - mode 0 receive done after last rising edge
// - mode 1 frame start, 8 data, stop
// - mode 1 rate timer overflow /16 or /32
// - each transmit bit follows a divider rollover
// - transmit done at 10th or 11th rollover
// - falling edge resets receive divider at once
// - bit value is majority of three samples
// - nonzero start bit aborts the frame
// - load only if flag clear and stop passes
// - after stop middle, hunt for falling edge
// - modes 2, 3 carry ninth bit both ways
// - mode 2 rate osc/32 or osc/64
// - mode 3 like mode 2, timer rate
// - any buffer write starts transmission
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module four_mode_serial_port
    import serial_port_pkg::*;
#(
    parameter int WB_ADDR_W = 4
)(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 timer_overflow_i,
    input  wire logic                 rxd_i,
    output logic                      rxd_o,
    output logic                      rxd_oe_o,
    output logic                      txd_o
);
    import serial_port_pkg::*;

    // the decoder compares a four-bit offset
    if (WB_ADDR_W < 4) begin : g_bad_width
        $error("WB_ADDR_W must be at least 4");
    end

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdat;
        logic [7:0]  rx_buf;
        logic        tx_done;
        logic        rx_done;
        logic        rx_ninth;
        logic        tx_ninth;
        logic        rx_en;
        logic        multiproc;
        logic        mode_hi;
        logic        mode_lo;
        logic        baud_dbl;
        logic        m0_busy;
        logic        m0_rx;
        logic [3:0]  m0_phase;
        logic [2:0]  m0_bit;
        logic [7:0]  m0_sr;
        logic [1:0]  pre;
        logic        ovf_half;
        logic        tick;
        logic [3:0]  tx_div;
        logic [3:0]  tx_left;
        logic [10:0] tx_sr;
        logic        txd;
        logic        rxd_out;
        logic        rx_s1;
        logic        rx_s2;
        logic        rx_prev;
        logic        rx_busy;
        logic [3:0]  rx_div;
        logic [3:0]  rx_bits;
        logic        smp_a;
        logic        smp_b;
        logic [8:0]  rx_sr;
    } state_s;

    state_s q;
    state_s d;

    mode_e      mode;
    logic       bus_req;
    logic       wr_en;
    logic [3:0] ofs;
    logic       wr_buf;
    logic       wr_ctrl;
    logic       set_ti;
    logic       set_ri;
    logic [3:0] m0_per;
    logic [3:0] m0_fall;
    logic [3:0] m0_rise;
    logic       tx_roll;
    logic       rx_decide;
    logic       rx_bit;
    logic [3:0] frame_len;
    logic       rx_last;
    logic       rx_accept;
    logic [3:0] ph_n;

    // decode and shared terms
    assign mode      = mode_e'({q.mode_hi, q.mode_lo});
    assign bus_req   = wb_cyc_i && wb_stb_i;
    assign ofs       = wb_adr_i[3:0];
    assign wr_en     = bus_req && q.ack && wb_we_i && wb_sel_i[0];
    assign wr_buf    = wr_en && (ofs == OFS_SERIAL_BUFFER);
    assign wr_ctrl   = wr_en && (ofs == OFS_SERIAL_CTRL);
    assign m0_per    = q.multiproc ? M0_PERIOD_FAST : M0_PERIOD_SLOW;
    assign m0_fall   = q.multiproc ? M0_LEAD_FAST : M0_LEAD_SLOW;
    assign m0_rise   = m0_fall + (q.multiproc ? M0_LOW_FAST : M0_LOW_SLOW);
    assign ph_n      = (q.m0_phase == m0_per - 4'h1) ? 4'h0 : q.m0_phase + 4'h1;
    assign tx_roll   = q.tick && (q.tx_div == DIV_LAST);
    assign rx_decide = q.rx_busy && q.tick && (q.rx_div == SMP_THIRD);
    // two of three vote, the third sample is the live one
    assign rx_bit    = (q.smp_a & q.smp_b) | (q.smp_a & q.rx_s2) | (q.smp_b & q.rx_s2);
    assign frame_len = (mode == MODE_UART8) ? FRAME_LEN_10 : FRAME_LEN_11;
    assign rx_last   = rx_decide && (q.rx_bits == frame_len - 4'h1);
    assign rx_accept = rx_last && !q.rx_done && (!q.multiproc || rx_bit);

    // outputs straight from flops, except rxd_oe_o, which is an AND of two of them
    assign wb_dat_o = {24'h00_0000, q.rdat};
    assign wb_ack_o = q.ack;
    assign txd_o    = q.txd;
    assign rxd_o    = q.rxd_out;
    assign rxd_oe_o = q.m0_busy && !q.m0_rx;

    // next state of the whole port
    always_comb
    begin
        d      = q;
        set_ti = 1'b0;
        set_ri = 1'b0;
        // wishbone: answer one cycle after the request, read data latched then
        d.ack  = bus_req && !q.ack;
        if (bus_req && !q.ack)
        begin
            unique case (ofs)
                OFS_SERIAL_BUFFER: d.rdat = q.rx_buf;
                OFS_SERIAL_CTRL:   d.rdat = {q.mode_hi, q.mode_lo, q.multiproc, q.rx_en,
                                             q.tx_ninth, q.rx_ninth, q.rx_done, q.tx_done};
                OFS_POWER_CTRL:    d.rdat = {q.baud_dbl, 7'h00};
                default:           d.rdat = 8'h00;
            endcase
        end
        // synchroniser for the incoming data pin
        d.rx_s1 = rxd_i;
        d.rx_s2 = q.rx_s1;
        // oversampling tick: osc/2 or osc/4 in mode 2, every or every second timer overflow otherwise
        d.tick = 1'b0;
        if (mode == MODE_FIXED)
        begin
            d.pre  = (q.pre == (q.baud_dbl ? PRE_DOUBLE : PRE_SINGLE)) ? 2'h0 : q.pre + 2'h1;
            d.tick = (q.pre == (q.baud_dbl ? PRE_DOUBLE : PRE_SINGLE));
        end
        else if (timer_overflow_i)
        begin
            d.ovf_half = !q.ovf_half;
            d.tick     = q.baud_dbl || q.ovf_half;
        end
        if (q.tick)
        begin
            d.tx_div = q.tx_div + 4'h1;
        end
        // mode 0 shift engine: phase 0 puts data out, clock low from fall to rise
        if (q.m0_busy)
        begin
            d.m0_phase = ph_n;
            d.txd      = !((ph_n >= m0_fall) && (ph_n < m0_rise));
            // receive takes the pin at the period end: the two-flop synchroniser
            // lags the pin by as much as the fast low time
            if (ph_n == 4'h0)
            begin
                d.m0_bit = q.m0_bit + 3'h1;
                if (q.m0_rx)
                begin
                    d.m0_sr = {q.rx_s2, q.m0_sr[7:1]};
                end
                else
                begin
                    d.m0_sr   = {1'b0, q.m0_sr[7:1]};
                    d.rxd_out = q.m0_sr[1];
                end
                if (q.m0_bit == M0_LAST_BIT)
                begin
                    set_ti    = !q.m0_rx;
                    set_ri    = q.m0_rx;
                    d.rx_buf  = q.m0_rx ? {q.rx_s2, q.m0_sr[7:1]} : q.rx_buf;
                    d.m0_busy = 1'b0;
                end
            end
        end
        else if (mode == MODE_SHIFT && q.rx_en && !q.rx_done && !wr_buf)
        begin
            d.m0_busy  = 1'b1;
            d.m0_rx    = 1'b1;
            d.m0_phase = 4'h0;
            d.m0_bit   = 3'h0;
        end
        // asynchronous transmitter: a bit per divider rollover
        if (mode != MODE_SHIFT && tx_roll && q.tx_left != 4'h0)
        begin
            d.txd     = q.tx_sr[0];
            d.tx_sr   = {1'b1, q.tx_sr[10:1]};
            d.tx_left = q.tx_left - 4'h1;
            set_ti    = (q.tx_left == 4'h1);
        end
        // a buffer write always starts a new transmission
        if (wr_buf)
        begin
            if (mode == MODE_SHIFT)
            begin
                d.m0_busy  = 1'b1;
                d.m0_rx    = 1'b0;
                d.m0_phase = 4'h0;
                d.m0_bit   = 3'h0;
                d.m0_sr    = wb_dat_i[7:0];
                d.rxd_out  = wb_dat_i[0];
                d.txd      = 1'b1;
            end
            else
            begin
                d.tx_left = frame_len;
                d.tx_sr   = (mode == MODE_UART8) ? {2'b11, wb_dat_i[7:0], 1'b0}
                                                 : {1'b1, q.tx_ninth, wb_dat_i[7:0], 1'b0};
            end
        end
        // asynchronous receiver: edge hunt, then vote in mid-bit
        if (mode == MODE_SHIFT || !q.rx_en)
        begin
            d.rx_busy = 1'b0;
        end
        else if (q.tick)
        begin
            d.rx_prev = q.rx_s2;
            if (!q.rx_busy && q.rx_prev && !q.rx_s2)
            begin
                d.rx_busy = 1'b1;
                d.rx_div  = 4'h0;
                d.rx_bits = 4'h0;
            end
            else if (q.rx_busy)
            begin
                d.rx_div = q.rx_div + 4'h1;
                if (q.rx_div == SMP_FIRST)
                begin
                    d.smp_a = q.rx_s2;
                end
                if (q.rx_div == SMP_SECOND)
                begin
                    d.smp_b = q.rx_s2;
                end
                if (rx_decide)
                begin
                    d.rx_bits = q.rx_bits + 4'h1;
                    if (q.rx_bits == 4'h0 && rx_bit)
                    begin
                        d.rx_busy = 1'b0;
                    end
                    else if (rx_last)
                    begin
                        d.rx_busy = 1'b0;
                        if (rx_accept)
                        begin
                            d.rx_buf   = (mode == MODE_UART8) ? q.rx_sr[8:1] : q.rx_sr[7:0];
                            d.rx_ninth = (mode == MODE_UART8) ? rx_bit : q.rx_sr[8];
                            set_ri     = 1'b1;
                        end
                    end
                    else if (q.rx_bits != 4'h0)
                    begin
                        d.rx_sr = {rx_bit, q.rx_sr[8:1]};
                    end
                end
            end
        end
        // software writes; a hardware set of tx_done or rx_done in the same cycle wins
        if (wr_ctrl)
        begin
            d.tx_done   = wb_dat_i[CTRL_TX_DONE];
            d.rx_done   = wb_dat_i[CTRL_RX_DONE];
            d.rx_ninth  = wb_dat_i[CTRL_RX_NINTH];
            d.tx_ninth  = wb_dat_i[CTRL_TX_NINTH];
            d.rx_en     = wb_dat_i[CTRL_RX_ENABLE];
            d.multiproc = wb_dat_i[CTRL_MULTIPROC];
            d.mode_lo   = wb_dat_i[CTRL_MODE_LOW];
            d.mode_hi   = wb_dat_i[CTRL_MODE_HIGH];
        end
        if (wr_en && (ofs == OFS_POWER_CTRL))
        begin
            d.baud_dbl = wb_dat_i[PCTRL_BAUD_DBL];
        end
        d.tx_done = d.tx_done | set_ti;
        d.rx_done = d.rx_done | set_ri;
    end

    // single register stage; idle lines rest high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q         <= '0;
            q.txd     <= 1'b1;
            q.rxd_out <= 1'b1;
            q.rx_s1   <= 1'b1;
            q.rx_s2   <= 1'b1;
            q.rx_prev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_low_fast;
        !txd_o[*2] ##1 txd_o;
    endsequence
    sequence s_low_slow;
        !txd_o[*6] ##1 txd_o;
    endsequence

    a_buffer_read: assert property (q.ack && bus_req && !wb_we_i && ofs == OFS_SERIAL_BUFFER
        |-> wb_dat_o[7:0] == $past(q.rx_buf)) else $error("buffer read wrong");
    a_fast_low: assert property ($fell(txd_o) && q.m0_busy && q.multiproc
        |-> s_low_fast) else $error("fast shift clock low time wrong");
    a_slow_low: assert property ($fell(txd_o) && q.m0_busy && !q.multiproc
        |-> s_low_slow) else $error("slow shift clock low time wrong");
    a_slow_lead: assert property ($changed(rxd_o) && rxd_oe_o && !q.multiproc
        |-> txd_o[*3] ##1 !txd_o) else $error("slow data lead wrong");
    a_fast_lead: assert property ($changed(rxd_o) && rxd_oe_o && q.multiproc
        |-> txd_o ##1 !txd_o) else $error("fast data lead wrong");
    a_tx_on_roll: assert property (mode != MODE_SHIFT && $changed(txd_o) && !$past(wr_ctrl)
        |-> $past(tx_roll)) else $error("async bit not on rollover");
    a_edge_reset: assert property (q.tick && !q.rx_busy && q.rx_prev && !q.rx_s2
        && q.rx_en && mode != MODE_SHIFT && !wr_ctrl
        |=> q.rx_busy && q.rx_div == 4'h0) else $error("divider not reset");
    a_start_abort: assert property (rx_decide && q.rx_bits == 4'h0 && rx_bit && !wr_ctrl
        |=> !q.rx_busy) else $error("bad start not aborted");
    a_frame_drop: assert property (rx_last && q.multiproc && !rx_bit && !q.rx_done && !wr_ctrl
        |=> !q.rx_done) else $error("frame accepted wrongly");
    a_flag_hold: assert property (q.rx_done && q.tx_done && !wr_ctrl
        |=> q.rx_done && q.tx_done) else $error("done flag cleared by hardware");
    a_no_m0_rx: assert property (q.rx_done && !q.m0_busy && !wr_ctrl
        |=> !(q.m0_busy && q.m0_rx)) else $error("receive while flag set");
endmodule

// [dv/serial_partner.sv]
// Purpose: far-side serial device for the four-mode serial port bench
// Assumes: the async line idles high; the mode-0 source obeys the shift clock
// Notes:   capture samples mid-bit, so rollover jitter of the sender is tolerated
`timescale 1ns/1ps
module serial_partner (
    input  wire logic        clk_i,
    input  wire logic        txd_i,
    input  wire logic        rxd_w_i,
    input  wire logic        oe_i,
    input  wire logic        async_en_i,
    input  wire logic [3:0]  nbits_i,
    input  wire logic [8:0]  bit_clks_i,
    input  wire logic [7:0]  src_i,
    output logic             drv_o,
    output logic             frm_done_o,
    output logic [10:0]      frm_o,
    output logic             m0_done_o,
    output logic [7:0]       m0_byte_o,
    output logic [3:0]       per_o,
    output logic [3:0]       low_o
);
    logic       tp_q   = 1'b1;
    logic [2:0] cnt_q  = 3'h0;
    logic [2:0] idx_q  = 3'h0;
    logic [3:0] run_q  = 4'h0;
    logic [3:0] lrun_q = 4'h0;

    // send one async frame, bit 0 first, then go back to the idle mark
    task automatic send(input logic [10:0] w, input int n, input int bc);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            drv_o <= w[i];
            repeat (bc - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        drv_o <= 1'b1;
    endtask

    // mode-0 source: a shift register moves its output on the falling shift clock
    // at once, so the next bit is on the pin well before the port samples it
    always @(negedge txd_i)
    begin
        if (!oe_i && !async_en_i)
        begin
            drv_o <= src_i[idx_q];
            idx_q <= idx_q + 3'h1;
        end
    end

    // mode-0 side: measures shift clock and sinks shifted data
    always @(posedge clk_i)
    begin
        tp_q <= txd_i;
        run_q <= run_q + 4'h1;
        lrun_q <= lrun_q + 4'h1;
        m0_done_o <= 1'b0;
        if (!txd_i && tp_q)
        begin
            lrun_q <= 4'h1;
        end
        if (txd_i && !tp_q && oe_i)
        begin
            run_q <= 4'h1;
            per_o <= run_q;
            low_o <= lrun_q;
            m0_byte_o <= {rxd_w_i, m0_byte_o[7:1]};
            cnt_q <= cnt_q + 3'h1;
            m0_done_o <= (cnt_q == 3'h7);
        end
    end

    // async capture of the port's transmit line, start bit included
    initial
    begin
        drv_o = 1'b1;
        frm_done_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            frm_done_o <= 1'b0;
            if (async_en_i && tp_q && !txd_i)
            begin
                repeat (bit_clks_i / 2) @(posedge clk_i);
                for (int i = 0; i < 11; i++)
                begin
                    frm_o[i] <= (i < nbits_i) ? txd_i : 1'b0;
                    repeat (bit_clks_i) @(posedge clk_i);
                end
                frm_done_o <= 1'b1;
            end
        end
    end
endmodule

// [dv/four_mode_serial_port_test.sv]
// Purpose: self-checking bench for the four-mode serial port
// Assumes: timer overflow is a pulse per rising edge of a 200 ns link clock
// Notes:   serial frames are checked by a monitor against queued notes
`timescale 1ns/1ps
module four_mode_serial_port_test;
    import serial_port_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ovf = 1'b0, lnk = 1'b0, lnk_q = 1'b0;
    logic [3:0]  adr = 4'h0, nbits = 4'ha;
    logic [31:0] dat = 32'h0000_0000, rdat, seed = 32'h0000_ac08;
    logic        ack, rxd_o, oe, txd, drv, frm_done, m0_done, async_en = 1'b0;
    logic [10:0] frm;
    logic [7:0]  m0_byte, src = 8'h00;
    logic [3:0]  per, low;
    logic [8:0]  bclk = 9'h080;
    logic        rxd_w;
    int          errors = 0, n_checks = 0;
    logic [15:0] aq [$], mq [$];
    logic [1:0]  mt [5] = '{MODE_UART8, MODE_UART8, MODE_FIXED, MODE_FIXED, MODE_TIMED};
    logic        db [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    int          bcs [5] = '{128, 256, 32, 64, 128};

    assign rxd_w = oe ? rxd_o : drv;

    four_mode_serial_port dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .timer_overflow_i(ovf), .rxd_i(rxd_w), .rxd_o(rxd_o),
        .rxd_oe_o(oe), .txd_o(txd));
    serial_partner p (.clk_i(clk_i), .txd_i(txd), .rxd_w_i(rxd_w), .oe_i(oe),
        .async_en_i(async_en), .nbits_i(nbits), .bit_clks_i(bclk), .src_i(src),
        .drv_o(drv), .frm_done_o(frm_done), .frm_o(frm), .m0_done_o(m0_done),
        .m0_byte_o(m0_byte), .per_o(per), .low_o(low));

    // clocks: the link clock is offset so its edges never meet those of clk_i
    initial forever #12.5 clk_i = ~clk_i;
    initial
    begin
        #7;
        forever #100 lnk = ~lnk;
    end
    always @(posedge clk_i)
    begin
        lnk_q <= lnk;
        ovf <= lnk & ~lnk_q;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic mp, ren, tb8);
        return {24'h0, m, mp, ren, tb8, 3'h0};
    endfunction
    task automatic bad(input string m);
        errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic cmp(input logic [31:0] g, e);
        n_checks++;
        if (g !== e) bad($sformatf("register got %h expected %h", g, e));
    endtask
    task automatic cmp_ser(input logic [15:0] g, e);
        n_checks++;
        if (g !== e) bad($sformatf("serial got %h expected %h", g, e));
    endtask
    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int t;
        t = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        r = rdat;
        if (t >= 50) bad("no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask
    // polls a flag; slow baud settings need many reads
    task automatic wflag(input int b);
        logic [31:0] r;
        int t;
        t = 0;
        r = 32'h0;
        while (r[b] !== 1'b1 && t < 9000)
        begin
            wb(1'b0, OFS_SERIAL_CTRL, 32'h0, r);
            t++;
        end
        if (t >= 9000) bad("flag never set");
    endtask
    task automatic qwait();
        int t;
        t = 0;
        while (aq.size() + mq.size() > 0 && t < 9000)
        begin
            @(posedge clk_i);
            t++;
        end
        if (t >= 9000) bad("frame not seen");
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // monitor: each frame seen on the wire takes the oldest note
    always @(posedge clk_i)
    begin
        if (frm_done === 1'b1) cmp_ser({5'h0, frm}, aq.size() > 0 ? aq.pop_front() : 'x);
        if (m0_done === 1'b1) cmp_ser({per, low, m0_byte}, mq.size() > 0 ? mq.pop_front() : 'x);
    end

    // the whole sequence needs about 12k cycles; this leaves room for slow polls
    initial
    begin
        repeat (40000) @(posedge clk_i);
        bad("watchdog");
        end_of_test();
    end

    // main sequence
    initial
    begin
        logic [7:0]  d, d2;
        logic [1:0]  m;
        logic        n9, tb8, rb8;
        logic [10:0] w;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(OFS_SERIAL_CTRL, 32'h0);
        rd_chk(OFS_POWER_CTRL, 32'h0);
        wr(4'hc, 32'h0000_00ff);
        rd_chk(4'hc, 32'h0);
        tdone("registers");
        // full duplex in every async mode and rate except mode 3 undoubled, table driven
        for (int k = 0; k < 5; k++)
        begin
            m = mt[k];
            {n9, tb8, d2, d} = 18'(xs());
            wr(OFS_POWER_CTRL, {24'h0, db[k], 7'h0});
            async_en <= 1'b1;
            nbits <= (m == MODE_UART8) ? 4'ha : 4'hb;
            bclk <= 9'(bcs[k]);
            wr(OFS_SERIAL_CTRL, ctl(m, 1'b0, 1'b1, tb8));
            aq.push_back(m == MODE_UART8 ? {6'h0, 1'b1, d, 1'b0} : {5'h0, 1'b1, tb8, d, 1'b0});
            wr(OFS_SERIAL_BUFFER, {24'h0, d});
            w = (m == MODE_UART8) ? {2'b01, d2, 1'b0} : {1'b1, n9, d2, 1'b0};
            rb8 = (m == MODE_UART8) ? 1'b1 : n9;
            p.send(w, (m == MODE_UART8) ? 10 : 11, bcs[k]);
            wflag(CTRL_RX_DONE);
            qwait();
            rd_chk(OFS_SERIAL_BUFFER, {24'h0, d2});
            rd_chk(OFS_SERIAL_CTRL, ctl(m, 1'b0, 1'b1, tb8) | {29'h0, rb8, 2'h3});
            wr(OFS_SERIAL_CTRL, 32'h0);
        end
        tdone("async modes");
        // glitch, then two frames back to back while the first is unread
        {d2, d} = 16'(xs());
        wr(OFS_POWER_CTRL, 32'h0000_0080);
        bclk <= 9'h080;
        wr(OFS_SERIAL_CTRL, ctl(MODE_UART8, 1'b0, 1'b1, 1'b0));
        p.send(11'h000, 1, 20);
        p.send(11'h7ff, 1, 128);
        p.send({2'b01, d, 1'b0}, 10, 128);
        p.send({2'b01, d2, 1'b0}, 10, 128);
        wflag(CTRL_RX_DONE);
        rd_chk(OFS_SERIAL_BUFFER, {24'h0, d});
        // multiprocessor filter: a zero final bit is dropped, a one is kept
        wr(OFS_SERIAL_CTRL, ctl(MODE_FIXED, 1'b1, 1'b1, 1'b0));
        p.send({2'b01, d2, 1'b0}, 11, 32);
        repeat (64) @(posedge clk_i);
        rd_chk(OFS_SERIAL_CTRL, ctl(MODE_FIXED, 1'b1, 1'b1, 1'b0));
        p.send({2'b11, d2, 1'b0}, 11, 32);
        wflag(CTRL_RX_DONE);
        rd_chk(OFS_SERIAL_BUFFER, {24'h0, d2});
        tdone("receive filter");
        // shift-register mode at both rates, out then in
        async_en <= 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            d = 8'(xs());
            wr(OFS_SERIAL_CTRL, ctl(MODE_SHIFT, s[0], 1'b0, 1'b0));
            mq.push_back({s[0] ? M0_PERIOD_FAST : M0_PERIOD_SLOW, s[0] ? M0_LOW_FAST : M0_LOW_SLOW, d});
            wr(OFS_SERIAL_BUFFER, {24'h0, d});
            wflag(CTRL_TX_DONE);
            qwait();
            src <= 8'(xs());
            wr(OFS_SERIAL_CTRL, ctl(MODE_SHIFT, s[0], 1'b1, 1'b0));
            wflag(CTRL_RX_DONE);
            rd_chk(OFS_SERIAL_BUFFER, {24'h0, src});
            n9 = 1'b0;
            repeat (40) @(posedge clk_i) n9 = n9 | ~txd;
            cmp({31'h0, n9}, 32'h0);
            wr(OFS_SERIAL_CTRL, 32'h0);
        end
        tdone("shift mode");
        end_of_test();
    end
endmodule
